// File: pwr_ctrl_pkg.sv
// Package of constants for the LED driver shutdown and spread-spectrum control block
//
// Contract
// RULE_01 - Range field selects one of four dither spans
// RULE_02 - Registers hold their values during any shutdown
// RULE_03 - Soft power-down bit low turns outputs off
// RULE_04 - Soft power-down bit resets to zero
// RULE_05 - Host writes one to enable outputs
// RULE_06 - Pin held low forces hardware shutdown
// RULE_07 - Pin returning high ends hardware shutdown
// RULE_08 - Pin rising edge resets serial interface only
// RULE_09 - Registers stay accessible while pin low
// RULE_10 - Host rewrites registers after deep supply dip
// RULE_11 - Reset register key restores all defaults
// RULE_12 - Shutdown forces channels off until both release
`default_nettype none
package pwr_ctrl_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR      = 8'h00; // Control register
   localparam logic [7:0] SPREAD_ADDR    = 8'h19; // Spread-spectrum register
   localparam logic [7:0] RESET_ADDR     = 8'h3f; // Reset register
   localparam logic [7:0] RESET_KEY      = 8'hae; // Value that restores defaults
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int         SOFT_PD_BIT    = 0;     // Soft power-down bit in control
   localparam int         RANGE_LSB      = 0;     // Range field low bit in spread reg
   localparam logic [7:0] CTRL_RESET     = 8'h00; // Control reset value
   localparam logic [7:0] SPREAD_RESET   = 8'h00; // Spread reset value
   // Dither range codes, percent of timebase
   localparam logic [1:0] RANGE_5        = 2'h0;
   localparam logic [1:0] RANGE_15       = 2'h1;
   localparam logic [1:0] RANGE_24       = 2'h2;
   localparam logic [1:0] RANGE_34       = 2'h3;
   localparam logic [5:0] SPAN_5         = 6'h05;
   localparam logic [5:0] SPAN_15        = 6'h0f;
   localparam logic [5:0] SPAN_24        = 6'h18;
   localparam logic [5:0] SPAN_34        = 6'h22;
   // Serial-interface reset pulse length in cycles
   localparam int         BUS_RST_CYCLES = 1;
endpackage
`default_nettype wire

// File: pin_sync.sv
// Two-stage synchroniser with rising-edge detect
`timescale 1ns/100ps
`default_nettype none
module pin_sync
(
   input  wire logic sys_clk_i,  // System clock
   input  wire logic arst_n_i,   // Async reset, active low
   input  wire logic async_i,    // Pin level from outside
   output logic      level_o,    // Synchronised level
   output logic      rise_o      // One-cycle pulse on rising edge
);
   logic stage1;      // First flop, read only by stage2
   logic stage2;      // Second flop
   logic stage3;      // Previous synchronised level
   logic next_stage1;
   logic next_stage2;
   logic next_stage3;

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   always_comb
   begin
      next_stage1 = async_i;
      next_stage2 = stage1;
      next_stage3 = stage2;
   end

   // Registers; pin treated as low (shutdown) during reset
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end
      else
      begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         stage3 <= next_stage3;
      end
   end

   assign level_o = stage2;
   assign rise_o  = stage2 & ~stage3;
endmodule
`default_nettype wire

// File: pwr_ctrl.sv
// Shutdown and spread-spectrum control for an 18-channel LED driver
`timescale 1ns/100ps
`default_nettype none
module pwr_ctrl
#(
   parameter int CHANNELS = 18   // Number of LED channels
)
(
   input  wire logic                sys_clk_i,          // 25 MHz clock
   input  wire logic                arst_n_i,           // Power-on reset, active low
   input  wire logic                hw_power_down_n_pin, // Shutdown pin, low = shutdown
   input  wire logic                reg_wr_i,           // Write strobe from serial engine
   input  wire logic                reg_rd_i,           // Read strobe from serial engine
   input  wire logic [7:0]          reg_addr_i,         // Register address
   input  wire logic [7:0]          reg_wdata_i,        // Write data
   output logic      [7:0]          reg_rdata_o,        // Read data, registered
   input  wire logic [CHANNELS-1:0] chan_mod_i,         // PWM/blink state per channel
   output logic      [CHANNELS-1:0] chan_en_o,          // Current source enables
   output logic                     soft_power_down_n,  // Soft power-down bit
   output logic                     hw_shutdown_o,      // Hardware shutdown active
   output logic      [1:0]          dither_range_select,// Range field
   output logic      [5:0]          dither_span_o,      // Dither span in percent
   output logic                     bus_rst_o           // Serial interface reset pulse
);
   // Elaboration check: the enable path is built for 1 to 32 channels
   if (CHANNELS < 1 || CHANNELS > 32)
   begin : g_bad_channels
      $error("CHANNELS out of range");
   end

   // ------------------------------------------------------------
   // Shutdown pin synchroniser
   // ------------------------------------------------------------
   logic pin_level;  // Synchronised pin level
   logic pin_rise;   // Rising edge pulse

   pin_sync u_pin_sync
   (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .async_i   (hw_power_down_n_pin),
      .level_o   (pin_level),
      .rise_o    (pin_rise)
   );

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0]          ctrl_reg;        // Control register
   logic [7:0]          spread_reg;      // Spread-spectrum register
   logic [7:0]          rdata;           // Read data
   logic                bus_rst;         // Interface reset pulse
   logic [CHANNELS-1:0] chan_en;         // Output enables
   logic [7:0]          next_ctrl_reg;
   logic [7:0]          next_spread_reg;
   logic [7:0]          next_rdata;
   logic                next_bus_rst;
   logic [CHANNELS-1:0] next_chan_en;
   logic                run_ok;          // Both shutdown conditions released
   logic [5:0]          span;            // Registered dither span
   logic [5:0]          next_span;       // Span decoded from the next range field

   // Register writes; pin level plays no part, so access continues
   // in shutdown and values are simply held [RULE_02] [RULE_09]
   always_comb
   begin
      next_ctrl_reg   = ctrl_reg;
      next_spread_reg = spread_reg;
      next_rdata      = rdata;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            pwr_ctrl_pkg::CTRL_ADDR:   next_ctrl_reg   = reg_wdata_i;
            pwr_ctrl_pkg::SPREAD_ADDR: next_spread_reg = reg_wdata_i;
            pwr_ctrl_pkg::RESET_ADDR:
            begin
               // Key restores defaults [RULE_11]
               if (reg_wdata_i == pwr_ctrl_pkg::RESET_KEY)
               begin
                  next_ctrl_reg   = pwr_ctrl_pkg::CTRL_RESET;
                  next_spread_reg = pwr_ctrl_pkg::SPREAD_RESET;
               end
            end
            default: ;
         endcase
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            pwr_ctrl_pkg::CTRL_ADDR:   next_rdata = ctrl_reg;
            pwr_ctrl_pkg::SPREAD_ADDR: next_rdata = spread_reg;
            default:                   next_rdata = 8'h00;
         endcase
      end
   end

   // Outputs gated by both shutdown modes [RULE_03] [RULE_06] [RULE_07] [RULE_12]
   assign run_ok = ctrl_reg[pwr_ctrl_pkg::SOFT_PD_BIT] & pin_level;

   always_comb
   begin
      next_chan_en = run_ok ? chan_mod_i : '0;
      // Pin rising edge resets the interface only [RULE_08]
      next_bus_rst = pin_rise;
   end

   // Registers; control resets to zero, soft shutdown [RULE_04]
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_reg   <= pwr_ctrl_pkg::CTRL_RESET;
         spread_reg <= pwr_ctrl_pkg::SPREAD_RESET;
         rdata      <= 8'h00;
         bus_rst    <= 1'b0;
         chan_en    <= '0;
         span       <= pwr_ctrl_pkg::SPAN_5;
      end
      else
      begin
         ctrl_reg   <= next_ctrl_reg;
         spread_reg <= next_spread_reg;
         rdata      <= next_rdata;
         bus_rst    <= next_bus_rst;
         chan_en    <= next_chan_en;
         span       <= next_span;
      end
   end

   // ------------------------------------------------------------
   // Range decode
   // ------------------------------------------------------------
   // Decoded from the next range value, so the registered span
   // changes on the same edge as the spread register
   always_comb
   begin
      // Four spans selected by the range field [RULE_01]
      case (next_spread_reg[pwr_ctrl_pkg::RANGE_LSB +: 2])
         pwr_ctrl_pkg::RANGE_5:  next_span = pwr_ctrl_pkg::SPAN_5;
         pwr_ctrl_pkg::RANGE_15: next_span = pwr_ctrl_pkg::SPAN_15;
         pwr_ctrl_pkg::RANGE_24: next_span = pwr_ctrl_pkg::SPAN_24;
         pwr_ctrl_pkg::RANGE_34: next_span = pwr_ctrl_pkg::SPAN_34;
         default:                next_span = pwr_ctrl_pkg::SPAN_5;
      endcase
   end

   assign dither_span_o       = span;

   assign dither_range_select = spread_reg[pwr_ctrl_pkg::RANGE_LSB +: 2];
   assign soft_power_down_n   = ctrl_reg[pwr_ctrl_pkg::SOFT_PD_BIT];
   assign hw_shutdown_o       = ~pin_level;
   assign chan_en_o           = chan_en;
   assign reg_rdata_o         = rdata;
   assign bus_rst_o           = bus_rst;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_soft_off;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      !ctrl_reg[pwr_ctrl_pkg::SOFT_PD_BIT] |=> chan_en_o == '0;
   endproperty
   a_soft_off: assert property (p_soft_off) else $error("outputs on in soft shutdown"); // [RULE_03]

   property p_hw_off;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      !pin_level |=> chan_en_o == '0;
   endproperty
   a_hw_off: assert property (p_hw_off) else $error("outputs on in hw shutdown"); // [RULE_06]

   property p_resume;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      run_ok |=> chan_en_o == $past(chan_mod_i);
   endproperty
   a_resume: assert property (p_resume) else $error("outputs not following modulation"); // [RULE_12]

   // Leaving hardware shutdown with the soft bit set restores modulation
   property p_exit_hw;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      ($rose(pin_level) && ctrl_reg[pwr_ctrl_pkg::SOFT_PD_BIT])
      |-> !hw_shutdown_o ##1 chan_en_o == $past(chan_mod_i);
   endproperty
   a_exit_hw: assert property (p_exit_hw) else $error("hw shutdown not left"); // [RULE_07]

   property p_bus_rst;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      pin_rise |=> bus_rst_o ##1 !bus_rst_o;
   endproperty
   a_bus_rst: assert property (p_bus_rst) else $error("interface reset pulse wrong"); // [RULE_08]

   property p_hold;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (!reg_wr_i && pin_rise) |=> $stable(ctrl_reg) && $stable(spread_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("registers changed on pin edge"); // [RULE_02]

   property p_wr_in_sd;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (reg_wr_i && reg_addr_i == pwr_ctrl_pkg::SPREAD_ADDR && !pin_level)
      |=> spread_reg == $past(reg_wdata_i);
   endproperty
   a_wr_in_sd: assert property (p_wr_in_sd) else $error("write lost in hw shutdown"); // [RULE_09]

   property p_key;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (reg_wr_i && reg_addr_i == pwr_ctrl_pkg::RESET_ADDR && reg_wdata_i == pwr_ctrl_pkg::RESET_KEY)
      |=> ctrl_reg == pwr_ctrl_pkg::CTRL_RESET && spread_reg == pwr_ctrl_pkg::SPREAD_RESET;
   endproperty
   a_key: assert property (p_key) else $error("reset key ignored"); // [RULE_11]

   property p_span;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      dither_range_select == pwr_ctrl_pkg::RANGE_34 |-> dither_span_o == pwr_ctrl_pkg::SPAN_34;
   endproperty
   a_span: assert property (p_span) else $error("span decode wrong"); // [RULE_01]

   property p_boot;
      @(posedge sys_clk_i) $rose(arst_n_i) |-> !soft_power_down_n;
   endproperty
   a_boot: assert property (p_boot) else $error("soft bit not zero after reset"); // [RULE_04]

   property p_cv_run;
      @(posedge sys_clk_i) disable iff (!arst_n_i) run_ok ##1 chan_en_o != '0;
   endproperty
   c_run: cover property (p_cv_run);

   property p_cv_rise;
      @(posedge sys_clk_i) disable iff (!arst_n_i) pin_rise;
   endproperty
   c_rise: cover property (p_cv_rise);

   property p_cv_key;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_addr_i == pwr_ctrl_pkg::RESET_ADDR;
   endproperty
   c_key: cover property (p_cv_key);
endmodule
`default_nettype wire

// File: host_model.sv
// Host controller model: drives register strobes and the shutdown pin
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   input  wire logic       sys_clk_i, // System clock
   input  wire logic [7:0] rdata_i,   // Read data from the block
   output logic            wr_o,      // Write strobe
   output logic            rd_o,      // Read strobe
   output logic      [7:0] addr_o,    // Register address
   output logic      [7:0] wdata_o,   // Write data
   output logic            pin_n_o    // Shutdown pin, low = shutdown
);
   // ---------------------------------------------
   // Idle state
   // ---------------------------------------------
   initial
   begin
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      addr_o  = 8'h55;
      wdata_o = 8'haa;
      pin_n_o = 1'b1;
   end
   // One write; released lines are inverted so stale values never pass
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_o    <= 1'b1;
      addr_o  <= a;
      wdata_o <= d;
      @(posedge sys_clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask
   // One read; data taken once the registered answer has landed
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      rd_o   <= 1'b1;
      addr_o <= a;
      @(posedge sys_clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(posedge sys_clk_i);
      #1;
      d = rdata_i;
   endtask
   // Pin level change, any order allowed
   task automatic set_pin(input logic v);
      @(posedge sys_clk_i);
      pin_n_o <= v;
   endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the shutdown and spread-spectrum control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ---------------------------------------------
   // Signals and counters
   // ---------------------------------------------
   localparam logic [17:0] MOD_A = 18'h2a5c3; // First channel pattern
   localparam logic [17:0] MOD_B = 18'h1d23c; // Second channel pattern
   logic        sys_clk_i, arst_n_i, pin_n, wr, rd, soft_power_down_n, hw_shutdown_o, bus_rst_o;
   logic [7:0]  addr, wdata, reg_rdata_o;
   logic [17:0] chan_mod_i, chan_en_o;
   logic [1:0]  dither_range_select;
   logic [5:0]  dither_span_o;
   int          n_mismatch, comparisons;
   // Clock, 40 ns period
   initial
   begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   host_model host (.sys_clk_i(sys_clk_i), .rdata_i(reg_rdata_o), .wr_o(wr), .rd_o(rd),
                    .addr_o(addr), .wdata_o(wdata), .pin_n_o(pin_n));
   pwr_ctrl dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .hw_power_down_n_pin(pin_n),
                 .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
                 .reg_rdata_o(reg_rdata_o), .chan_mod_i(chan_mod_i), .chan_en_o(chan_en_o),
                 .soft_power_down_n(soft_power_down_n), .hw_shutdown_o(hw_shutdown_o),
                 .dither_range_select(dither_range_select), .dither_span_o(dither_span_o),
                 .bus_rst_o(bus_rst_o));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [17:0] seen, input logic [17:0] expected);
      comparisons++;
      if (seen !== expected)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask
   // Bounded wait for the channel enables, ends the run if they never match
   task automatic wait_en(input logic [17:0] exp);
      #1;
      for (int i = 0; i < 8 && chan_en_o !== exp; i++)
      begin
         @(posedge sys_clk_i);
         #1;
      end
      check(chan_en_o, exp);
      if (chan_en_o !== exp)
         complete_run();
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic sc_reset_state();
      logic [7:0] d;
      check(soft_power_down_n, 1'b0);
      check(chan_en_o, 18'h00000);
      check(dither_span_o, pwr_ctrl_pkg::SPAN_5);
      host.read_reg(pwr_ctrl_pkg::CTRL_ADDR, d);
      check(d, pwr_ctrl_pkg::CTRL_RESET);
   endtask
   // Enable, follow the modulation, soft off and back on
   task automatic sc_enable();
      logic [7:0] d;
      host.write_reg(pwr_ctrl_pkg::CTRL_ADDR, 8'h01);
      wait_en(MOD_A);
      @(posedge sys_clk_i);
      chan_mod_i <= MOD_B;
      wait_en(MOD_B);
      host.write_reg(pwr_ctrl_pkg::CTRL_ADDR, 8'h00);
      wait_en(18'h00000);
      host.read_reg(pwr_ctrl_pkg::CTRL_ADDR, d);
      check(d, 8'h00);
      host.write_reg(pwr_ctrl_pkg::CTRL_ADDR, 8'h01);
      wait_en(MOD_B);
   endtask
   // Every range code, its span and its read-back
   task automatic sc_ranges();
      logic [5:0] span [4] = '{pwr_ctrl_pkg::SPAN_5, pwr_ctrl_pkg::SPAN_15,
                               pwr_ctrl_pkg::SPAN_24, pwr_ctrl_pkg::SPAN_34};
      logic [7:0] d;
      for (int k = 0; k < 4; k++)
      begin
         host.write_reg(pwr_ctrl_pkg::SPREAD_ADDR, {6'h00, k[1:0]});
         @(posedge sys_clk_i);
         #1;
         check(dither_range_select, k[1:0]);
         check(dither_span_o, span[k]);
         host.read_reg(pwr_ctrl_pkg::SPREAD_ADDR, d);
         check(d, {6'h00, k[1:0]});
      end
   endtask
   // Pin low, access during shutdown, release with one interface reset pulse
   task automatic sc_hw_shutdown();
      logic [7:0] d;
      int         n;
      host.set_pin(1'b0);
      wait_en(18'h00000);
      check(hw_shutdown_o, 1'b1);
      host.write_reg(pwr_ctrl_pkg::SPREAD_ADDR, 8'h02);
      host.write_reg(pwr_ctrl_pkg::CTRL_ADDR, 8'h01);
      host.read_reg(pwr_ctrl_pkg::SPREAD_ADDR, d);
      check(d, 8'h02);
      check(soft_power_down_n, 1'b1);
      host.set_pin(1'b1);
      n = 0;
      repeat (8)
      begin
         @(posedge sys_clk_i);
         #1;
         if (bus_rst_o === 1'b1)
            n++;
      end
      check(18'(n), 18'h00001);
      check(hw_shutdown_o, 1'b0);
      check(chan_en_o, MOD_B);
      check(dither_range_select, 2'h2);
   endtask
   // Wrong key ignored, right key restores defaults
   task automatic sc_reset_key();
      logic [7:0] d;
      host.write_reg(pwr_ctrl_pkg::RESET_ADDR, 8'h12);
      host.read_reg(pwr_ctrl_pkg::CTRL_ADDR, d);
      check(d, 8'h01);
      host.write_reg(pwr_ctrl_pkg::RESET_ADDR, pwr_ctrl_pkg::RESET_KEY);
      wait_en(18'h00000);
      check(soft_power_down_n, 1'b0);
      host.read_reg(pwr_ctrl_pkg::SPREAD_ADDR, d);
      check(d, pwr_ctrl_pkg::SPREAD_RESET);
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      arst_n_i    = 1'b0;
      chan_mod_i  = MOD_A;
      n_mismatch  = 0;
      comparisons = 0;
      repeat (16) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      #1;
      sc_reset_state();
      sc_enable();
      sc_ranges();
      sc_hw_shutdown();
      sc_reset_key();
      complete_run();
   end
endmodule
`default_nettype wire
